// ===== design/dsfc_top.sv
// Behaviour
// - input, offset codes are binary when coding pin low, twos complement when high
// - gain, control and command words always decoded as straight binary
// - monitor enable field zero disables monitor output, releasing it
// - enabled, kind zero: four select bits pick one of sixteen channels
// - enabled, kind one: select bit zero picks monitor input zero or one
// - special-function code 001101 writes the general-purpose pin register
// - direction field one makes pin output driven to level field
// - both fields zero make the pin an input, driver released
// - pin register readback shows current pin level in bit zero
// - power-down bit one forces every channel output to signal ground
// - power-down keeps registers; clearing restores previous outputs
// - thermal enable plus over-temperature enters power-down
// - entering thermal shutdown sets the over-temperature flag bit four
// - thermal shutdown persists until thermal enable bit cleared
// - each channel keeps computed levels A and B, updated on input write
// - each select register holds eight channel select bits
// - busy held low about 600 ns after select register write
// - special-function words carry mode code 00 in leading bits
// - data writes go to input A when control A/B bit 0, else B
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dsfc_cfg.svh"
module dsfc_top (
	input wire logic clk,
	input wire logic srst,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hsel,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic data_coding_select,
	input wire logic over_temp_in,
	input wire logic gpio_in,
	output logic gpio_out,
	output logic gpio_oe,
	output logic monitor_output_en,
	output logic [1:0] monitor_source,
	output logic [3:0] monitor_channel,
	output logic [15:0] signal_ground_ref,
	output logic busy_n
);
	localparam int BUSY_CYC = `DSFC_BUSY_CYC;
	dsfc_pkg::dsfc_ctrl_t ctrl_ff;
	dsfc_pkg::dsfc_mon_t mon_ff;
	logic [1:0] gpio_ff;
	logic [15:0] absel_ff;
	logic [15:0] xdata_ff;
	logic [3:0] chan_ff;
	logic [15:0] input_level_a [16];
	logic [15:0] input_level_b [16];
	logic [15:0] computed_level_a [16];
	logic [15:0] computed_level_b [16];
	logic [15:0] out_level_ff [16];
	logic [4:0] busy_cnt_ff;
	logic wr_pend_ff;
	logic [11:0] wr_addr_ff;
	logic ot_sync;
	logic gpio_sync;
	logic wr_now;
	logic [23:0] sf_word;
	logic sf_valid;
	logic [5:0] sf_code;
	logic ab_write;
	logic x_write;

	// convert the selected coding to straight offset binary
	function automatic logic [15:0] to_offset(input logic [15:0] v, input logic twos);
		to_offset = twos ? {~v[15], v[14:0]} : v;
	endfunction

	// pick a channel's stored level by its select bit
	function automatic logic [15:0] pick(input logic sel, input logic [15:0] a,
		input logic [15:0] b);
		pick = sel ? b : a;
	endfunction

	dsfc_sync u_ot_sync (
		.clk(clk),
		.srst(srst),
		.din(over_temp_in),
		.dout(ot_sync)
	);
	dsfc_sync u_gpio_sync (
		.clk(clk),
		.srst(srst),
		.din(gpio_in),
		.dout(gpio_sync)
	);

	assign wr_now = wr_pend_ff;
	assign sf_word = hwdata[23:0];
	// mode code 00 marks special words
	assign sf_valid = wr_now && (wr_addr_ff == `DSFC_ADDR_SFWORD) &&
		(sf_word[23:22] == `DSFC_SF_MODE);
	// command code decoded as plain binary
	assign sf_code = sf_word[21:16];
	assign ab_write = sf_valid && ((sf_code == `DSFC_SF_AB0) || (sf_code == `DSFC_SF_AB1));
	assign x_write = wr_now && (wr_addr_ff == `DSFC_ADDR_XDATA);

	// ahb address phase capture
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 12'h000;
		end else if (hready) begin
			wr_pend_ff <= hsel && htrans[1] && hwrite;
			wr_addr_ff <= haddr[11:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr[11:0])
				`DSFC_ADDR_CTRL: hrdata <= {27'h0, ctrl_ff.therm_flag, 1'b0, ctrl_ff.ab_sel,
					ctrl_ff.therm_en, ctrl_ff.power_down};
				`DSFC_ADDR_MON: hrdata <= {26'h0, mon_ff};
				`DSFC_ADDR_GPIO: hrdata <= {29'h0, gpio_ff, gpio_sync};
				`DSFC_ADDR_ABSEL0: hrdata <= {24'h0, absel_ff[7:0]};
				`DSFC_ADDR_ABSEL1: hrdata <= {24'h0, absel_ff[15:8]};
				`DSFC_ADDR_XDATA: hrdata <= {16'h0, xdata_ff};
				`DSFC_ADDR_CHAN: hrdata <= {28'h0, chan_ff};
				`DSFC_ADDR_STATUS: hrdata <= {31'h0, busy_n};
				`DSFC_ADDR_LVLA: hrdata <= {16'h0, computed_level_a[chan_ff]};
				`DSFC_ADDR_LVLB: hrdata <= {16'h0, computed_level_b[chan_ff]};
				`DSFC_ADDR_OUT: hrdata <= {16'h0, out_level_ff[chan_ff]};
				`DSFC_ADDR_INA: hrdata <= {16'h0, input_level_a[chan_ff]};
				`DSFC_ADDR_INB: hrdata <= {16'h0, input_level_b[chan_ff]};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			xdata_ff <= 16'h0000;
			chan_ff <= 4'h0;
		end else if (wr_now && wr_addr_ff == `DSFC_ADDR_XDATA) begin
			xdata_ff <= hwdata[15:0];
		end else if (wr_now && wr_addr_ff == `DSFC_ADDR_CHAN) begin
			chan_ff <= hwdata[3:0];
		end
	end

	// control register, thermal shutdown sticky
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_ff <= '0;
		end else begin
			if (sf_valid && sf_code == `DSFC_SF_CTRL) begin
				ctrl_ff.power_down <= sf_word[`DSFC_CTRL_PD];
				ctrl_ff.therm_en <= sf_word[`DSFC_CTRL_TEN];
				ctrl_ff.ab_sel <= sf_word[`DSFC_CTRL_AB];
				if (!sf_word[`DSFC_CTRL_TEN]) begin
					ctrl_ff.therm_flag <= 1'b0;
				end
			end
			if (ctrl_ff.therm_en && ot_sync) begin
				ctrl_ff.therm_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mon_ff <= '0;
		end else if (sf_valid && sf_code == `DSFC_SF_MON) begin
			mon_ff <= sf_word[5:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			gpio_ff <= 2'h0;
		end else if (sf_valid && sf_code == `DSFC_SF_GPIO) begin
			gpio_ff <= sf_word[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			gpio_oe <= 1'b0;
			gpio_out <= 1'b0;
		end else begin
			gpio_oe <= gpio_ff[`DSFC_GPIO_DIR];
			gpio_out <= gpio_ff[`DSFC_GPIO_DIR] & gpio_ff[`DSFC_GPIO_LVL];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			monitor_output_en <= 1'b0;
			monitor_source <= dsfc_pkg::DSFC_SRC_NONE;
			monitor_channel <= 4'h0;
		end else begin
			monitor_output_en <= mon_ff.enable;
			monitor_channel <= mon_ff.sel;
			if (!mon_ff.enable) begin
				monitor_source <= dsfc_pkg::DSFC_SRC_NONE;
			end else if (!mon_ff.kind) begin
				monitor_source <= dsfc_pkg::DSFC_SRC_CHAN;
			end else if (mon_ff.sel[0]) begin
				monitor_source <= dsfc_pkg::DSFC_SRC_IN1;
			end else begin
				monitor_source <= dsfc_pkg::DSFC_SRC_IN0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			absel_ff <= 16'h0000;
		end else if (ab_write) begin
			if (sf_code == `DSFC_SF_AB0) begin
				absel_ff[7:0] <= sf_word[7:0];
			end else begin
				absel_ff[15:8] <= sf_word[7:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			busy_cnt_ff <= 5'h00;
			busy_n <= 1'b1;
		end else if (ab_write) begin
			busy_cnt_ff <= 5'(BUSY_CYC - 1);
			busy_n <= 1'b0;
		end else if (busy_cnt_ff != 5'h00) begin
			busy_cnt_ff <= busy_cnt_ff - 5'h01;
		end else begin
			busy_n <= 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_chan
			// route input write by A/B bit
			always_ff @(posedge clk) begin
				if (srst) begin
					input_level_a[g] <= 16'h0000;
					input_level_b[g] <= 16'h0000;
					computed_level_a[g] <= 16'h8000;
					computed_level_b[g] <= 16'h8000;
				end else if (x_write && chan_ff == 4'(g)) begin
					// take the word from the data phase, the data register lags a cycle
					if (!ctrl_ff.ab_sel) begin
						input_level_a[g] <= hwdata[15:0];
						computed_level_a[g] <= to_offset(hwdata[15:0], data_coding_select);
					end else begin
						input_level_b[g] <= hwdata[15:0];
						computed_level_b[g] <= to_offset(hwdata[15:0], data_coding_select);
					end
				end
			end
			always_ff @(posedge clk) begin
				if (srst) begin
					out_level_ff[g] <= 16'h8000;
					signal_ground_ref[g] <= 1'b1;
				end else begin
					signal_ground_ref[g] <= ctrl_ff.power_down | ctrl_ff.therm_flag;
					out_level_ff[g] <= pick(absel_ff[g], computed_level_a[g],
						computed_level_b[g]);
				end
			end
		end
	endgenerate

	a_busy_width: assert property (@(posedge clk) disable iff (srst)
		ab_write |=> !busy_n [*8])
		else $error("busy released too early");
	a_therm_stick: assert property (@(posedge clk) disable iff (srst)
		(ctrl_ff.therm_flag && !(sf_valid && sf_code == `DSFC_SF_CTRL)) |=> ctrl_ff.therm_flag)
		else $error("thermal flag lost");
	a_therm_set: assert property (@(posedge clk) disable iff (srst)
		(ctrl_ff.therm_en && ot_sync) |=> ctrl_ff.therm_flag)
		else $error("thermal flag not set");
	a_pd_ground: assert property (@(posedge clk) disable iff (srst)
		ctrl_ff.power_down |=> (signal_ground_ref == 16'hffff))
		else $error("power-down not grounding");
	a_mon_off: assert property (@(posedge clk) disable iff (srst)
		!mon_ff.enable |=> !monitor_output_en && monitor_source == dsfc_pkg::DSFC_SRC_NONE)
		else $error("monitor not released");
	a_mon_chan: assert property (@(posedge clk) disable iff (srst)
		(mon_ff.enable && !mon_ff.kind) |=> monitor_source == dsfc_pkg::DSFC_SRC_CHAN
		&& monitor_channel == $past(mon_ff.sel))
		else $error("channel select wrong");
	a_mon_inp: assert property (@(posedge clk) disable iff (srst)
		(mon_ff.enable && mon_ff.kind && mon_ff.sel[0]) |=> monitor_source == dsfc_pkg::DSFC_SRC_IN1)
		else $error("monitor input select wrong");
	a_gpio_drv: assert property (@(posedge clk) disable iff (srst)
		gpio_ff[1] |=> gpio_oe && gpio_out == $past(gpio_ff[0]))
		else $error("pin not driven");
	a_gpio_rel: assert property (@(posedge clk) disable iff (srst)
		gpio_ff == 2'h0 |=> !gpio_oe)
		else $error("pin not released");
	a_busy_end: assert property (@(posedge clk) disable iff (srst)
		(busy_cnt_ff == 5'h00 && !busy_n && !ab_write) |=> busy_n)
		else $error("busy not released");
	a_therm_clear: assert property (@(posedge clk) disable iff (srst)
		(sf_valid && sf_code == `DSFC_SF_CTRL && !sf_word[`DSFC_CTRL_TEN]
		&& !(ctrl_ff.therm_en && ot_sync)) |=> !ctrl_ff.therm_flag)
		else $error("thermal flag not cleared");
	a_therm_ground: assert property (@(posedge clk) disable iff (srst)
		ctrl_ff.therm_flag |=> (signal_ground_ref == 16'hffff))
		else $error("thermal shutdown not grounding");
	a_pd_release: assert property (@(posedge clk) disable iff (srst)
		(!ctrl_ff.power_down && !ctrl_ff.therm_flag) |=> (signal_ground_ref == 16'h0000))
		else $error("outputs not restored");
	a_monitor_input_zero: assert property (@(posedge clk) disable iff (srst)
		(mon_ff.enable && mon_ff.kind && !mon_ff.sel[0])
		|=> monitor_source == dsfc_pkg::DSFC_SRC_IN0)
		else $error("monitor input zero not selected");
	c_ab_write: cover property (@(posedge clk) disable iff (srst) ab_write);
	c_therm: cover property (@(posedge clk) disable iff (srst) $rose(ctrl_ff.therm_flag));
	c_gpio: cover property (@(posedge clk) disable iff (srst) sf_valid && sf_code == `DSFC_SF_GPIO);
	c_pd_ground: cover property (@(posedge clk) disable iff (srst) $rose(ctrl_ff.power_down));
	c_mon_input: cover property (@(posedge clk) disable iff (srst)
		monitor_source == dsfc_pkg::DSFC_SRC_IN1);
endmodule
`default_nettype wire

// ===== design/dsfc_cfg.svh
`ifndef DSFC_CFG_SVH
`define DSFC_CFG_SVH
`define DSFC_ADDR_CTRL 12'h000
`define DSFC_ADDR_MON 12'h004
`define DSFC_ADDR_GPIO 12'h008
`define DSFC_ADDR_ABSEL0 12'h00c
`define DSFC_ADDR_ABSEL1 12'h010
`define DSFC_ADDR_XDATA 12'h014
`define DSFC_ADDR_CHAN 12'h018
`define DSFC_ADDR_SFWORD 12'h01c
`define DSFC_ADDR_STATUS 12'h020
`define DSFC_ADDR_LVLA 12'h024
`define DSFC_ADDR_LVLB 12'h028
`define DSFC_ADDR_OUT 12'h02c
`define DSFC_ADDR_INA 12'h030
`define DSFC_ADDR_INB 12'h034
`define DSFC_CTRL_PD 0
`define DSFC_CTRL_TEN 1
`define DSFC_CTRL_AB 2
`define DSFC_CTRL_OT 4
`define DSFC_MON_EN 5
`define DSFC_MON_KIND 4
`define DSFC_GPIO_DIR 1
`define DSFC_GPIO_LVL 0
`define DSFC_SF_MODE 2'h0
`define DSFC_SF_GPIO 6'h0d
`define DSFC_SF_CTRL 6'h01
`define DSFC_SF_MON 6'h0c
`define DSFC_SF_AB0 6'h0e
`define DSFC_SF_AB1 6'h0f
`define DSFC_CLK_NS 25
`define DSFC_BUSY_NS 600
`define DSFC_BUSY_CYC ((`DSFC_BUSY_NS + `DSFC_CLK_NS - 1) / `DSFC_CLK_NS)
`endif

// ===== design/dsfc_pkg.sv
package dsfc_pkg;
	typedef struct packed {
		logic therm_flag;
		logic ab_sel;
		logic therm_en;
		logic power_down;
	} dsfc_ctrl_t;
	typedef struct packed {
		logic enable;
		logic kind;
		logic [3:0] sel;
	} dsfc_mon_t;
	typedef enum logic [1:0] {
		DSFC_SRC_NONE,
		DSFC_SRC_CHAN,
		DSFC_SRC_IN0,
		DSFC_SRC_IN1
	} dsfc_src_t;
endpackage

// ===== design/dsfc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output changes once stages two and three agree
module dsfc_sync (
	input wire logic clk,
	input wire logic srst,
	input wire logic din,
	output logic dout
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	always_ff @(posedge clk) begin
		if (srst) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			dout <= 1'b0;
		end else if (s2_ff == s3_ff) begin
			dout <= s3_ff;
		end
	end
endmodule
`default_nettype wire

// ===== tb/dsfc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsfc_pin_model #(
	parameter int TRIP_C = 130
) (
	input wire logic gpio_out,
	input wire logic gpio_oe,
	input wire logic ext_level,
	input var int temp_c,
	output logic gpio_in,
	output logic over_temp_in
);
	assign gpio_in = gpio_oe ? gpio_out : ext_level;
	assign over_temp_in = temp_c > TRIP_C;
endmodule
`default_nettype wire

// ===== tb/dac_special_function_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsfc_cfg.svh"
module dac_special_function_control_tb_top;
	typedef struct packed {
		logic [23:0] w;
		logic [8:0] e;
	} dsfc_row_t;
	logic clk, srst, hwrite, hsel, hreadyout, hresp, dcs, ext_level, ot, gpio_in;
	logic gpio_out, gpio_oe, mon_en, busy_n;
	logic [1:0] htrans, mon_src;
	logic [2:0] hsize;
	logic [3:0] mon_ch;
	logic [15:0] gnd;
	logic [31:0] haddr, hwdata, hrdata, r;
	int temp_c, error_cnt, n_checks, i, n;
	// word, then {oe, out, monitor enable, source, channel}
	dsfc_row_t rows [0:7] = '{'{24'h0c0025, 9'h055}, '{24'h0c003f, 9'h07f},
		'{24'h0c0030, 9'h060}, '{24'h0c000f, 9'h00f}, '{24'h4c0025, 9'h00f},
		'{24'h0d0003, 9'h18f}, '{24'h0d0002, 9'h10f}, '{24'h0d0000, 9'h00f}};

	dsfc_top u_dut (.clk(clk), .srst(srst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .data_coding_select(dcs),
		.over_temp_in(ot), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.monitor_output_en(mon_en), .monitor_source(mon_src), .monitor_channel(mon_ch),
		.signal_ground_ref(gnd), .busy_n(busy_n));
	dsfc_pin_model u_pins (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_level(ext_level),
		.temp_c(temp_c), .gpio_in(gpio_in), .over_temp_in(ot));

	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic sf(input logic [5:0] c, input logic [15:0] d);
		xfer(1'b1, `DSFC_ADDR_SFWORD, {8'h0, `DSFC_SF_MODE, c, d});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(r, e);
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		$display("unexpected at %0t: watchdog expired", $time);
		error_cnt++;
		complete_run();
	end
	initial begin
		srst = 1'b1;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		hsize = 3'h2;
		hsel = 1'b1;
		dcs = 1'b0;
		ext_level = 1'b1;
		temp_c = 25;
		error_cnt = 0;
		n_checks = 0;
		repeat (5) @(posedge clk);
		chk(32'(gnd), 32'hffff);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'({gpio_oe, mon_en, busy_n, gnd}), 32'h10000);
		for (i = 0; i < 8; i++) begin
			xfer(1'b1, `DSFC_ADDR_SFWORD, {8'h0, rows[i].w});
			repeat (2) @(posedge clk);
			chk(32'({gpio_oe, gpio_out, mon_en, mon_src, mon_ch}),
				32'(rows[i].e));
		end
		repeat (6) @(posedge clk);
		rd(`DSFC_ADDR_GPIO, 32'h1);
		ext_level <= 1'b0;
		repeat (6) @(posedge clk);
		rd(`DSFC_ADDR_GPIO, 32'h0);
		sf(`DSFC_SF_GPIO, 16'h3);
		repeat (6) @(posedge clk);
		rd(`DSFC_ADDR_GPIO, 32'h7);
		rd(12'h0fc, 32'h0);
		chk(32'(hresp), 32'h0);
		xfer(1'b1, `DSFC_ADDR_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		chk(32'(gnd), 32'h0);
		xfer(1'b1, `DSFC_ADDR_CHAN, 32'h3);
		xfer(1'b1, `DSFC_ADDR_XDATA, 32'h1234);
		rd(`DSFC_ADDR_LVLA, 32'h1234);
		dcs <= 1'b1;
		sf(`DSFC_SF_CTRL, 16'h4);
		rd(`DSFC_ADDR_CTRL, 32'h4);
		xfer(1'b1, `DSFC_ADDR_XDATA, 32'h1234);
		rd(`DSFC_ADDR_LVLB, 32'h9234);
		rd(`DSFC_ADDR_LVLA, 32'h1234);
		rd(`DSFC_ADDR_INB, 32'h1234);
		rd(`DSFC_ADDR_INA, 32'h1234);
		dcs <= 1'b0;
		sf(`DSFC_SF_AB0, 16'h8);
		n = 0;
		repeat (40) begin
			@(posedge clk);
			if (busy_n === 1'b0) n++;
		end
		chk(32'(n), 32'(`DSFC_BUSY_CYC));
		rd(`DSFC_ADDR_OUT, 32'h9234);
		rd(`DSFC_ADDR_ABSEL0, 32'h8);
		sf(`DSFC_SF_AB1, 16'h80);
		rd(`DSFC_ADDR_ABSEL1, 32'h80);
		rd(`DSFC_ADDR_OUT, 32'h9234);
		sf(`DSFC_SF_CTRL, 16'h1);
		repeat (2) @(posedge clk);
		chk(32'(gnd), 32'hffff);
		sf(`DSFC_SF_CTRL, 16'h0);
		repeat (2) @(posedge clk);
		chk(32'(gnd), 32'h0);
		rd(`DSFC_ADDR_OUT, 32'h9234);
		sf(`DSFC_SF_CTRL, 16'h2);
		temp_c <= 131;
		repeat (2) @(posedge clk);
		chk(32'(gnd), 32'h0);
		repeat (8) @(posedge clk);
		chk(32'(gnd), 32'hffff);
		rd(`DSFC_ADDR_CTRL, 32'h12);
		temp_c <= 25;
		repeat (8) @(posedge clk);
		chk(32'(gnd), 32'hffff);
		sf(`DSFC_SF_CTRL, 16'h0);
		repeat (2) @(posedge clk);
		chk(32'(gnd), 32'h0);
		rd(`DSFC_ADDR_CTRL, 32'h0);
		// reset in mid-run while powered down
		sf(`DSFC_SF_CTRL, 16'h1);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'(gnd), 32'h0);
		rd(`DSFC_ADDR_ABSEL1, 32'h0);
		rd(`DSFC_ADDR_STATUS, 32'h1);
		complete_run();
	end
endmodule
`default_nettype wire
